// ===== logic/spicsc_fifo.sv
`timescale 1ns/1ps

module spicsc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic full;
        logic empty;
    } spicsc_fifo_s;

    spicsc_fifo_s st;
    spicsc_fifo_s next_st;
    logic push;
    logic pop;
    logic [AW:0] next_count;

    assign in_ready = !st.full;
    assign out_valid = !st.empty;
    assign out_data = st.mem[st.rd_ptr];

    // ==========================================================
    // Pointer and flag update.
    always_comb begin
        next_st = st;
        push = in_valid && !st.full;
        pop = out_ready && !st.empty;
        next_count = st.count;
        if (push) begin
            next_st.mem[st.wr_ptr] = in_data;
            next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_count = st.count - 1'b1;
        end
        next_st.count = next_count;
        next_st.full = (next_count == (AW + 1)'(DEPTH));
        next_st.empty = (next_count == '0);
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st <= '0;
            st.empty <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

endmodule

// ===== logic/spicsc_pkg.sv
package spicsc_pkg;

    // ==========================================================
    // Geometry of the select lines, of the transmit word and of the DMA channel.
    localparam int CS_COUNT = 4;
    localparam int CODE_W = 4;
    localparam int WORD_W = 32;
    localparam int DATA_MAX_W = 16;
    localparam int CODE_LSB = 16;
    localparam int LAST_BIT = 24;
    localparam int DELAY_W = 8;
    localparam int COUNT_W = 16;
    localparam int PTR_W = 32;

    // ==========================================================
    // Values after reset and fixed counts.
    localparam logic [CS_COUNT-1:0] CS_ALL_HIGH = 4'hf;
    localparam logic [CODE_W-1:0] CODE_NONE = 4'hf;
    localparam int DELAY_UNIT_CYCLES = 32;
    localparam int FIFO_DEPTH = 8;

    // ==========================================================
    // Size of one unit moved by the DMA channel.
    localparam logic [1:0] UNIT_BYTE = 2'h0;
    localparam logic [1:0] UNIT_HALF = 2'h1;
    localparam logic [1:0] UNIT_WORD = 2'h2;

    // ==========================================================
    // Sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SHIFT = 4'h2,
        ST_GAP = 4'h4,
        ST_HOLD = 4'h8
    } spicsc_state_e;

endpackage

// ===== logic/spicsc_top.sv
`timescale 1ns/1ps

module spicsc_top
    import spicsc_pkg::*;
#(
    parameter int FIFO_W = WORD_W,
    parameter int FIFO_D = FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic enable_command,
    input wire logic disable_command,
    input wire logic select_mode_bit,
    input wire logic [CODE_W-1:0] mode_chip_select_code,
    input wire logic [CS_COUNT-1:0] hold_select_after_transfer,
    input wire logic [CS_COUNT-1:0][DELAY_W-1:0] between_transfer_delay,
    input wire logic [4:0] bits_per_transfer,
    input wire logic tx_write,
    input wire logic [WORD_W-1:0] transmit_data_register,
    output logic tx_ready,
    input wire logic dma_start,
    input wire logic [PTR_W-1:0] dma_start_ptr,
    input wire logic [COUNT_W-1:0] dma_start_count,
    input wire logic dma_next_load,
    input wire logic [PTR_W-1:0] dma_next_ptr,
    input wire logic [COUNT_W-1:0] dma_next_count,
    input wire logic [1:0] dma_unit,
    output logic mem_req,
    output logic [PTR_W-1:0] mem_addr,
    output logic [1:0] mem_size,
    input wire logic [WORD_W-1:0] mem_rdata,
    input wire logic mem_ack,
    output logic dma_active,
    output logic dma_end,
    output logic [COUNT_W-1:0] dma_remaining,
    input wire logic link_clk,
    input wire logic miso,
    output logic sck,
    output logic mosi,
    output logic [CS_COUNT-1:0] chip_select_lines_n,
    output logic [DATA_MAX_W-1:0] rx_data,
    output logic rx_valid,
    output logic transmit_empty_flag,
    output logic spi_enabled
);

    typedef struct packed {
        spicsc_state_e state;
        logic enabled;
        logic [CS_COUNT-1:0] cs_n;
        logic [CODE_W-1:0] cur_code;
        logic cur_last;
        logic sck;
        logic mosi;
        logic [DATA_MAX_W-1:0] shreg;
        logic [DATA_MAX_W-1:0] rxreg;
        logic [4:0] bitcnt;
        logic [15:0] gap;
        logic [DATA_MAX_W-1:0] rx_data;
        logic rx_valid;
        logic txe;
        logic [1:0] clk_sync;
        logic clk_prev;
        logic [1:0] miso_sync;
        logic dma_active;
        logic dma_end;
        logic req;
        logic [PTR_W-1:0] cur_ptr;
        logic [COUNT_W-1:0] cur_cnt;
        logic [PTR_W-1:0] nxt_ptr;
        logic [COUNT_W-1:0] nxt_cnt;
        logic [1:0] unit;
    } spicsc_top_s;

    spicsc_top_s st;
    spicsc_top_s next_st;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [FIFO_W-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [FIFO_W-1:0] fifo_out_data;
    logic link_rise;
    logic link_fall;
    logic [CODE_W-1:0] word_code;
    logic [CS_COUNT-1:0] word_cs_n;
    logic [1:0] sel_idx;
    logic load_char;
    logic release_now;

    // ==========================================================
    // Select code decoding.
    // lowest zero wins
    function automatic logic [CS_COUNT-1:0] decode_select(input logic [CODE_W-1:0] code);
        logic [CS_COUNT-1:0] lines;
        lines = CS_ALL_HIGH;
        for (int i = CS_COUNT - 1; i >= 0; i--) begin
            if (!code[i]) begin
                lines = CS_ALL_HIGH;
                lines[i] = 1'b0;
            end
        end
        return lines;
    endfunction

    function automatic logic [1:0] select_index(input logic [CS_COUNT-1:0] lines);
        logic [1:0] idx;
        idx = '0;
        for (int i = CS_COUNT - 1; i >= 0; i--) begin
            if (!lines[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [WORD_W-1:0] unit_mask(input logic [1:0] unit);
        case (unit)
            UNIT_BYTE: unit_mask = 32'h0000_00ff;
            UNIT_HALF: unit_mask = 32'h0000_ffff;
            default: unit_mask = 32'hffff_ffff;
        endcase
    endfunction

    // ==========================================================
    // Transmit FIFO.
    spicsc_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_D)
    ) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    assign link_rise = st.clk_sync[1] && !st.clk_prev;
    assign link_fall = !st.clk_sync[1] && st.clk_prev;

    assign word_code = select_mode_bit ? fifo_out_data[CODE_LSB +: CODE_W] : mode_chip_select_code;
    assign word_cs_n = decode_select(word_code);
    assign sel_idx = select_index(st.cs_n);

    // ==========================================================
    // Sequencer, shifter and DMA channel.
    always_comb begin
        next_st = st;
        fifo_in_valid = 1'b0;
        fifo_in_data = '0;
        fifo_out_ready = 1'b0;
        load_char = 1'b0;
        release_now = 1'b0;
        next_st.clk_sync = {st.clk_sync[0], link_clk};
        next_st.clk_prev = st.clk_sync[1];
        next_st.miso_sync = {st.miso_sync[0], miso};
        next_st.rx_valid = 1'b0;
        next_st.unit = dma_unit;
        if (enable_command) begin
            next_st.enabled = 1'b1;
        end
        if (disable_command) begin
            next_st.enabled = 1'b0;
        end

        case (st.state)
            ST_IDLE: begin
                if (st.enabled && fifo_out_valid) begin
                    load_char = 1'b1;
                end
            end
            ST_SHIFT: begin
                if (link_rise) begin
                    next_st.sck = 1'b1;
                    next_st.rxreg = {st.rxreg[DATA_MAX_W-2:0], st.miso_sync[1]};
                    next_st.bitcnt = st.bitcnt + 1'b1;
                end else if (link_fall && st.sck) begin
                    next_st.sck = 1'b0;
                    if (st.bitcnt == bits_per_transfer) begin
                        next_st.rx_data = st.rxreg;
                        next_st.rx_valid = 1'b1;
                        next_st.gap = 16'(between_transfer_delay[sel_idx] * DELAY_UNIT_CYCLES);
                        next_st.state = ST_GAP;
                    end else begin
                        next_st.shreg = {st.shreg[DATA_MAX_W-2:0], 1'b0};
                        next_st.mosi = st.shreg[DATA_MAX_W-2];
                    end
                end
            end
            ST_GAP: begin
                if (st.gap != '0) begin
                    next_st.gap = st.gap - 1'b1;
                end else if (!hold_select_after_transfer[sel_idx] || st.cur_last
                             || !st.enabled || disable_command) begin
                    release_now = 1'b1;
                end else begin
                    next_st.state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!st.enabled) begin
                    release_now = 1'b1;
                end else if (fifo_out_valid) begin
                    if (word_cs_n == st.cs_n) begin
                        load_char = 1'b1;
                    end else begin
                        release_now = 1'b1;
                    end
                end
            end
            default: begin
                release_now = 1'b1;
            end
        endcase

        if (release_now) begin
            next_st.cs_n = CS_ALL_HIGH;
            next_st.state = ST_IDLE;
        end
        if (load_char) begin
            fifo_out_ready = 1'b1;
            next_st.cs_n = word_cs_n;
            next_st.cur_code = word_code;
            next_st.cur_last = select_mode_bit && fifo_out_data[LAST_BIT];
            next_st.shreg = 16'(fifo_out_data[DATA_MAX_W-1:0] << (5'(DATA_MAX_W) - bits_per_transfer));
            next_st.mosi = fifo_out_data[bits_per_transfer - 5'h1];
            next_st.bitcnt = '0;
            next_st.sck = 1'b0;
            next_st.state = ST_SHIFT;
        end
        next_st.txe = !fifo_out_valid && (next_st.state == ST_IDLE || next_st.state == ST_HOLD)
                      && !st.dma_active;

        if (dma_start && st.enabled) begin
            next_st.dma_active = 1'b1;
            next_st.dma_end = 1'b0;
            next_st.cur_ptr = dma_start_ptr;
            next_st.cur_cnt = dma_start_count;
        end
        if (dma_next_load) begin
            next_st.nxt_ptr = dma_next_ptr;
            next_st.nxt_cnt = dma_next_count;
        end
        if (st.dma_active) begin
            if (st.req) begin
                if (mem_ack) begin
                    fifo_in_valid = 1'b1;
                    fifo_in_data = mem_rdata & unit_mask(dma_unit);
                    next_st.req = 1'b0;
                    case (dma_unit)
                        UNIT_BYTE: next_st.cur_ptr = st.cur_ptr + 32'h1;
                        UNIT_HALF: next_st.cur_ptr = st.cur_ptr + 32'h2;
                        default: next_st.cur_ptr = st.cur_ptr + 32'h4;
                    endcase
                    next_st.cur_cnt = st.cur_cnt - 1'b1;
                end
            end else if (st.cur_cnt == '0) begin
                if (next_st.nxt_cnt == '0) begin
                    next_st.dma_active = 1'b0;
                    next_st.dma_end = 1'b1;
                end else begin
                    next_st.cur_ptr = next_st.nxt_ptr;
                    next_st.cur_cnt = next_st.nxt_cnt;
                    next_st.nxt_ptr = '0;
                    next_st.nxt_cnt = '0;
                end
            end else if (fifo_in_ready && st.enabled) begin
                next_st.req = 1'b1;
            end
        end else if (tx_write && fifo_in_ready) begin
            fifo_in_valid = 1'b1;
            fifo_in_data = transmit_data_register;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st <= '0;
            st.state <= ST_IDLE;
            st.cs_n <= CS_ALL_HIGH;
            st.cur_code <= CODE_NONE;
            st.txe <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs.
    assign tx_ready = fifo_in_ready;
    assign mem_req = st.req;
    assign mem_addr = st.cur_ptr;
    assign mem_size = st.unit;
    assign dma_active = st.dma_active;
    assign dma_end = st.dma_end;
    assign dma_remaining = st.cur_cnt;
    assign sck = st.sck;
    assign mosi = st.mosi;
    assign chip_select_lines_n = st.cs_n;
    assign rx_data = st.rx_data;
    assign rx_valid = st.rx_valid;
    assign transmit_empty_flag = st.txe;
    assign spi_enabled = st.enabled;

endmodule

// ===== testbench/spicsc_assertions.sv
`timescale 1ns/1ps

module spicsc_assertions
    import spicsc_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic enable_command,
    input wire logic disable_command,
    input wire logic [1:0] dma_unit,
    input wire logic mem_req,
    input wire logic [PTR_W-1:0] mem_addr,
    input wire logic mem_ack,
    input wire logic dma_active,
    input wire logic dma_end,
    input wire logic [COUNT_W-1:0] dma_remaining,
    input wire logic sck,
    input wire logic [CS_COUNT-1:0] chip_select_lines_n,
    input wire logic rx_valid,
    input wire logic transmit_empty_flag,
    input wire logic spi_enabled
);
    logic [PTR_W-1:0] step;
    assign step = (dma_unit == UNIT_BYTE) ? 32'h1 : ((dma_unit == UNIT_HALF) ? 32'h2 : 32'h4);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    // ==========================================================
    // Select lines.
    // single select line
    one_low_a:
        assert property ($onehot0(~chip_select_lines_n)) else $error("two select lines low");
    idle_sck_a:
        assert property (chip_select_lines_n == CS_ALL_HIGH |-> !sck) else $error("sck while idle");
    off_release_a:
        assert property ((!spi_enabled && transmit_empty_flag)[*4] |->
            chip_select_lines_n == CS_ALL_HIGH) else $error("select held while disabled");

    // ==========================================================
    // Commands.
    // enable takes effect
    enable_a:
        assert property (enable_command && !disable_command |=> spi_enabled)
            else $error("enable not taken");
    disable_a:
        assert property (disable_command |=> !spi_enabled) else $error("disable not taken");

    // ==========================================================
    // DMA channel.
    // pointer step size
    step_a:
        assert property (mem_req && mem_ack && dma_remaining > 16'h1 |=>
            mem_addr == $past(mem_addr) + $past(step)) else $error("pointer step wrong");
    count_a:
        assert property (mem_req && mem_ack && dma_remaining > 16'h1 |=>
            dma_remaining == $past(dma_remaining) - 16'h1) else $error("count not decremented");
    end_a:
        assert property ($rose(dma_end) |-> !dma_active && dma_remaining == 16'h0)
            else $error("end flag while active");
    req_hold_a:
        assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
            else $error("request dropped early");

    rx_c: cover property (rx_valid);
    end_c: cover property ($rose(dma_end));
    off_c: cover property (disable_command && chip_select_lines_n != CS_ALL_HIGH);
endmodule

bind spicsc_top spicsc_assertions spicsc_assertions_i (.mclk, .reset, .enable_command,
    .disable_command, .dma_unit, .mem_req, .mem_addr, .mem_ack, .dma_active, .dma_end,
    .dma_remaining, .sck, .chip_select_lines_n, .rx_valid, .transmit_empty_flag, .spi_enabled);

// ===== testbench/spicsc_slave_model.sv
`timescale 1ns/1ps

// ==========================================================
// Serial slave that answers a fixed byte and records what it hears.
module spicsc_slave_model #(
    parameter logic [7:0] REPLY = 8'h3c
) (
    input wire logic sck,
    input wire logic mosi,
    input wire logic [3:0] chip_select_lines_n,
    output logic miso,
    output logic [7:0] captured
);
    logic [7:0] shift_out;
    logic selected;
    assign selected = (chip_select_lines_n != 4'hf);
    initial begin
        miso = 1'b0;
        captured = 8'h00;
        shift_out = 8'h00;
    end
    always @(posedge selected) begin
        shift_out = {REPLY[6:0], 1'b0};
        miso = REPLY[7];
    end
    // A released line shows the inverse of its last level.
    always @(negedge selected) begin
        miso = ~miso;
    end
    always @(posedge sck) begin
        if (selected) begin
            captured = {captured[6:0], mosi};
        end
    end
    always @(negedge sck) begin
        if (selected) begin
            miso = shift_out[7];
            shift_out = {shift_out[6:0], 1'b0};
        end
    end
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps

module tb;
    import spicsc_pkg::*;
    logic mclk, reset, enable_command, disable_command, select_mode_bit, tx_write, tx_ready;
    logic [3:0] mode_chip_select_code, hold_select_after_transfer, chip_select_lines_n;
    logic [3:0][7:0] between_transfer_delay;
    logic [4:0] bits_per_transfer;
    logic [31:0] transmit_data_register, mem_rdata, dma_start_ptr, dma_next_ptr, mem_addr;
    logic [15:0] dma_start_count, dma_next_count, dma_remaining, rx_data;
    logic [1:0] dma_unit, mem_size;
    logic dma_start, dma_next_load, mem_req, mem_ack, dma_active, dma_end, link_clk, miso;
    logic sck, mosi, rx_valid, transmit_empty_flag, spi_enabled;
    logic [7:0] captured;
    logic [31:0] addr_q[$];
    int errors, comparisons;

    spicsc_top spicsc_top_i (.mclk, .reset, .enable_command, .disable_command, .select_mode_bit,
        .mode_chip_select_code, .hold_select_after_transfer, .between_transfer_delay,
        .bits_per_transfer, .tx_write, .transmit_data_register, .tx_ready, .dma_start,
        .dma_start_ptr, .dma_start_count, .dma_next_load, .dma_next_ptr, .dma_next_count,
        .dma_unit, .mem_req, .mem_addr, .mem_size, .mem_rdata, .mem_ack, .dma_active, .dma_end,
        .dma_remaining, .link_clk, .miso, .sck, .mosi, .chip_select_lines_n, .rx_data, .rx_valid,
        .transmit_empty_flag, .spi_enabled);
    spicsc_slave_model spicsc_slave_model_i (.sck, .mosi, .chip_select_lines_n, .miso, .captured);

    // ==========================================================
    // Clocks and memory.
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        link_clk = 1'b0;
        #37;
        forever #400 link_clk = ~link_clk;
    end
    always @(negedge mclk) begin
        if (reset) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'hffff_ff3c;
        end else if (mem_req === 1'b1) begin
            mem_ack <= 1'b1;
            mem_rdata <= 32'h0000_00c3;
            addr_q.push_back(mem_addr);
        end
    end

    // ==========================================================
    // Helpers.
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic test_done();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic command(input logic en, input logic dis);
        @(negedge mclk);
        enable_command = en;
        disable_command = dis;
        @(negedge mclk);
        enable_command = 1'b0;
        disable_command = 1'b0;
    endtask
    task automatic send(input logic [3:0] code, input logic last, input logic [7:0] data);
        @(negedge mclk);
        tx_write = 1'b1;
        transmit_data_register = {7'h00, last, 4'h0, code, 8'h00, data};
        @(negedge mclk);
        tx_write = 1'b0;
    endtask
    task automatic wait_rx();
        for (int n = 0; n < 400 && rx_valid !== 1'b1; n++) @(negedge mclk);
        check("rx_valid", 1, rx_valid);
    endtask
    task automatic wait_cs(input logic [3:0] want, input int limit, input string name);
        for (int n = 0; n < limit && chip_select_lines_n !== want; n++) @(negedge mclk);
        check(name, want, chip_select_lines_n);
    endtask
    task automatic wait_empty();
        for (int n = 0; n < 3000 && transmit_empty_flag !== 1'b1; n++) @(negedge mclk);
        check("tx_empty", 1, transmit_empty_flag);
    endtask
    task automatic start_dma(input logic [1:0] unit);
        @(negedge mclk);
        dma_unit = unit;
        dma_start = 1'b1;
        dma_start_ptr = 32'h100;
        dma_start_count = 16'h2;
        @(negedge mclk);
        dma_start = 1'b0;
        dma_next_load = 1'b1;
        dma_next_ptr = 32'h200;
        dma_next_count = 16'h1;
        @(negedge mclk);
        dma_next_load = 1'b0;
    endtask

    // ==========================================================
    // Scenarios.
    task automatic t_fixed();
        mode_chip_select_code = 4'hd;
        command(1'b1, 1'b0);
        check("enabled", 1, spi_enabled);
        send(4'he, 1'b0, 8'ha5);
        wait_cs(4'hd, 40, "cs_fixed");
        wait_rx();
        check("slave_data", 8'ha5, captured);
        check("rx_data", 8'h3c, rx_data[7:0]);
        wait_cs(4'hf, 40, "cs_after");
    endtask
    task automatic t_variable();
        logic [3:0] code;
        select_mode_bit = 1'b1;
        for (int i = 0; i < 4; i++) begin
            code = ~(4'h1 << i);
            send(code, 1'b0, 8'h50 + 8'(i));
            wait_cs(code, 40, "cs_variable");
            wait_rx();
            check("slave_var", 8'h50 + 8'(i), captured);
            wait_cs(4'hf, 40, "cs_var_after");
        end
    endtask
    task automatic t_delay();
        int n;
        between_transfer_delay[2] = 8'h02;
        send(4'hb, 1'b0, 8'h77);
        wait_rx();
        for (n = 0; n < 200 && chip_select_lines_n !== 4'hf; n++) @(negedge mclk);
        check("gap_ok", 1, n >= 2 * DELAY_UNIT_CYCLES - 2 && n <= 2 * DELAY_UNIT_CYCLES + 6);
        between_transfer_delay[2] = 8'h00;
    endtask
    task automatic t_hold();
        select_mode_bit = 1'b0;
        mode_chip_select_code = 4'he;
        hold_select_after_transfer = 4'h1;
        send(4'h0, 1'b0, 8'h11);
        wait_rx();
        wait_empty();
        repeat (8) @(negedge mclk);
        check("cs_held", 4'he, chip_select_lines_n);
        command(1'b0, 1'b1);
        wait_cs(4'hf, 6, "cs_disabled");
        start_dma(UNIT_BYTE);
        repeat (4) @(negedge mclk);
        check("dma_refused", 0, dma_active);
        command(1'b1, 1'b0);
        select_mode_bit = 1'b1;
        send(4'he, 1'b1, 8'h22);
        wait_rx();
        wait_cs(4'hf, 80, "cs_last");
        hold_select_after_transfer = 4'h0;
    endtask
    task automatic t_fifo();
        int got;
        select_mode_bit = 1'b0;
        command(1'b0, 1'b1);
        tx_write = 1'b1;
        transmit_data_register = 32'h0000_00e1;
        repeat (FIFO_DEPTH) @(negedge mclk);
        tx_write = 1'b0;
        @(negedge mclk);
        check("fifo_full", 0, tx_ready);
        command(1'b1, 1'b0);
        got = 0;
        for (int n = 0; n < 1500 && got < FIFO_DEPTH; n++) begin
            @(negedge mclk);
            got += int'(rx_valid);
        end
        check("fifo_drained", FIFO_DEPTH, got);
        wait_empty();
    endtask
    task automatic t_dma();
        for (int u = 0; u < 3; u++) begin
            addr_q.delete();
            mode_chip_select_code = ~(4'h1 << u);
            start_dma(2'(u));
            wait_cs(~(4'h1 << u), 200, "cs_dma");
            for (int n = 0; n < 3000 && dma_end !== 1'b1; n++) @(negedge mclk);
            check("dma_end", 1, dma_end);
            check("dma_units", 3, addr_q.size());
            check("addr0", 32'h100, addr_q[0]);
            check("addr1", 32'h100 + (32'h1 << u), addr_q[1]);
            check("addr2", 32'h200, addr_q[2]);
            check("remaining", 0, dma_remaining);
            check("mem_size", u, mem_size);
            wait_empty();
            check("dma_data", 8'hc3, captured);
        end
    endtask

    // ==========================================================
    // Main sequence and watchdog.
    initial begin
        reset = 1'b1;
        {enable_command, disable_command, select_mode_bit, tx_write} = 4'h0;
        {dma_start, dma_next_load} = 2'h0;
        mode_chip_select_code = 4'hf;
        hold_select_after_transfer = 4'h0;
        between_transfer_delay = 32'h0;
        bits_per_transfer = 5'h08;
        transmit_data_register = 32'h0;
        {dma_start_ptr, dma_next_ptr} = 64'h0;
        {dma_start_count, dma_next_count} = 32'h0;
        dma_unit = 2'h0;
        repeat (3) @(negedge mclk);
        reset = 1'b0;
        check("cs_reset", 4'hf, chip_select_lines_n);
        check("off_reset", 0, spi_enabled);
        t_fixed();
        t_variable();
        t_delay();
        t_hold();
        t_fifo();
        t_dma();
        test_done();
    end
    initial begin
        #3_000_000;
        errors++;
        test_done();
    end
endmodule
